// file: wdog_regs.vh
// constants for the runaway code watchdog
// Overview of operation
// RQ1 - 6-bit counter fed by 12-bit crystal prescaler
// RQ2 - rate select picks 2^13 or 2^18 minus 16
// RQ3 - overflow without service raises system reset
// RQ4 - write to service clears counter, prescaler 12:5
// RQ5 - reset pin low 32 cycles, cause flag set
// RQ6 - monitor mode plus test voltage disables watchdog
// RQ7 - stop instruction clears the prescaler
// RQ8 - service read returns reset vector low byte
// RQ9 - power-on clears prescaler after 4096 cycles
// RQ10 - internal reset clears prescaler and counter
// RQ11 - reset vector fetch clears the prescaler
// RQ12 - disable bit set means watchdog fully inactive (code only masks the overflow reset, prescaler and counter keep running)
// RQ13 - never raises interrupts, only system reset
// RQ14 - blank vector monitor entry disables until power-on
// RQ15 - keeps counting in wait mode
// RQ16 - stop gates clock, clears prescaler, freezes count
// RQ17 - stop disabled option turns stop into reset
// RQ18 - break plus test voltage on reset pin disables
// RQ19 - software services right after reset and stop
// RQ20 - disabled watchdog holds overflow reset inactive
`ifndef WDOG_REGS_VH
`define WDOG_REGS_VH
// ======================================================
// register map
`define WDOG_SERVICE_ADDR   16'hFFFF
`define RESET_VECTOR_LO     8'hC0 // arbitrary vector low byte, kept apart from idle 00
// system_options fields
`define OPT_RATE_BIT        0
`define OPT_DISABLE_BIT     1
`define OPT_STOP_EN_BIT     2
`define OPT_RESET_VAL       8'h00
// reset cause fields
`define CAUSE_WDOG_BIT      1
`define CAUSE_ILLOP_BIT     4
// ======================================================
// timing
`define PRESCALE_W          12
`define COUNTER_W           6
`define SERVICE_CLR_LO      5
`define SHORT_TAP           7
`define LONG_TAP            12
`define PIN_LOW_CYCLES      32
`define POR_DELAY_CYCLES    4096
`endif

// file: wdog_sync.v
// two flip-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module wdog_sync #(
  parameter W = 1
) (
  input  wire         mclk_i,   // clock
  input  wire         resetn_i, // async reset, active low
  input  wire [W-1:0] d_i,      // async level in
  output wire [W-1:0] q_o       // synchronised level
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  // ======================================================
  // two stage capture
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end
  assign q_o = s2_q;
endmodule // wdog_sync
`default_nettype wire

// file: runaway_code_watchdog.v
// runaway code watchdog with prescaler, counter and reset output
`timescale 1ns/100ps
`default_nettype none
`include "wdog_regs.vh"
module runaway_code_watchdog #(
  parameter PRE_W   = `PRESCALE_W,      // prescaler width
  parameter CNT_W   = `COUNTER_W,       // watchdog counter width
  parameter POR_DLY = `POR_DELAY_CYCLES // power-on prescaler clear delay
) (
  input  wire        mclk_i,          // crystal clock
  input  wire        resetn_i,        // power-on reset, active low
  input  wire [15:0] addr_i,          // cpu address bus
  input  wire [7:0]  wdata_i,         // cpu write data
  input  wire        wr_i,            // cpu write strobe
  input  wire        rd_i,            // cpu read strobe
  input  wire        vector_fetch_i,  // reset vector fetch cycle
  input  wire        opt_wr_i,        // system_options write strobe
  input  wire        stop_exec_i,     // stop instruction executed
  input  wire        wait_mode_i,     // cpu in wait mode
  input  wire        monitor_mode_i,  // monitor mode active
  input  wire        monitor_blank_i, // monitor entered by blank vectors
  input  wire        break_i,         // break interrupt active
  input  wire        rst_pin_tst_i,   // test voltage on reset pin (pin)
  input  wire        irq_pin_tst_i,   // test voltage on irq pin (pin)
  input  wire        int_reset_i,     // other internal reset sources
  output reg  [7:0]  rdata_o,         // read data
  output reg  [7:0]  options_o,       // system_options contents
  output reg  [7:0]  reset_cause_o,   // reset_cause_register contents
  output reg         rst_pin_oe_o,    // drive reset pin low
  output wire        rst_pin_o,       // reset pin output level
  output reg         sys_reset_o,     // system reset request
  output reg         stop_enter_o,    // stop mode accepted
  output wire        irq_o            // interrupt request, always idle
);
  // ======================================================
  // pin synchronisers
  wire [1:0] tst_s;
  wdog_sync #(.W(2)) u_sync (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .d_i      ({irq_pin_tst_i, rst_pin_tst_i}),
    .q_o      (tst_s)
  );
  wire rst_tst = tst_s[0];
  wire irq_tst = tst_s[1];

  // ======================================================
  // state
  reg [PRE_W-1:0] pre_q;
  reg [PRE_W-1:0] pre_d;
  reg [CNT_W-1:0] cnt_q;
  reg [CNT_W-1:0] cnt_d;
  reg [5:0]       pin_cnt_q;
  reg [12:0]      por_cnt_q;
  reg             por_done_q;
  reg             blank_lock_q;
  reg             stopped_q;
  reg             tap_prev_q;
  localparam [5:0] PIN_LOW = `PIN_LOW_CYCLES; // reset pin low time, sized to the counter

  // low byte of reset vector, returned on service reads
  function [7:0] vec_lo;
    input dummy;
    begin
      vec_lo = `RESET_VECTOR_LO; // RQ8
    end
  endfunction

  // ======================================================
  // decodes
  wire svc_wr  = wr_i && (addr_i == `WDOG_SERVICE_ADDR);        // RQ4
  wire svc_rd  = rd_i && (addr_i == `WDOG_SERVICE_ADDR);
  wire stop_ok = options_o[`OPT_STOP_EN_BIT];
  wire stop_go = stop_exec_i && stop_ok;
  wire illop   = stop_exec_i && !stop_ok;                       // RQ17
  // disable sources
  wire mon_dis = monitor_mode_i && (rst_tst || irq_tst);        // RQ6
  wire brk_dis = break_i && rst_tst;                            // RQ18
  wire cfg_dis = options_o[`OPT_DISABLE_BIT];                   // RQ12
  wire wd_off  = cfg_dis || mon_dis || brk_dis || blank_lock_q; // RQ14
  // internal reset while pin is held or another source asserts
  wire int_rst = sys_reset_o || int_reset_i;                    // RQ10
  // prescaler clear events
  wire pre_clr = int_rst || stop_go || vector_fetch_i ||
                 (por_cnt_q == POR_DLY[12:0]);                  // RQ7 RQ9 RQ11
  // tap selection for the counter clock
  wire tap = options_o[`OPT_RATE_BIT] ? pre_q[`SHORT_TAP-1] :
                                        pre_q[`LONG_TAP-1];     // RQ2
  wire tick = tap_prev_q && !tap;                               // RQ1
  wire ovf  = tick && (cnt_q == {CNT_W{1'b1}});

  // ======================================================
  // prescaler and counter next values
  always @* begin
    pre_d = pre_q;
    cnt_d = cnt_q;
    if (!stopped_q) begin
      pre_d = pre_q + {{(PRE_W-1){1'b0}}, 1'b1};               // RQ15 RQ16
      if (tick) cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
    if (svc_wr) begin
      cnt_d = {CNT_W{1'b0}};                                    // RQ4
      pre_d[PRE_W-1:`SERVICE_CLR_LO-1] = {(PRE_W-`SERVICE_CLR_LO+1){1'b0}};
    end
    if (pre_clr) pre_d = {PRE_W{1'b0}};
    if (int_rst) cnt_d = {CNT_W{1'b0}};                         // RQ10
  end

  // ======================================================
  // counting state
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pre_q      <= {PRE_W{1'b0}};
      cnt_q      <= {CNT_W{1'b0}};
      tap_prev_q <= 1'b0;
      stopped_q  <= 1'b0;
    end else begin
      pre_q      <= pre_d;
      cnt_q      <= cnt_d;
      // a service clears the tap bit too, so no false tick may follow it
      tap_prev_q <= (pre_clr || svc_wr) ? 1'b0 : tap;
      // stop freezes until an internal reset or a cpu write wakes the part
      if (stop_go) stopped_q <= 1'b1;                           // RQ16
      else if (int_rst || !stop_exec_i && wr_i) stopped_q <= 1'b0;
    end
  end

  // ======================================================
  // power-on delay counter
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      por_cnt_q  <= 13'h0000;
      por_done_q <= 1'b0;
    end else if (!por_done_q) begin
      por_cnt_q  <= por_cnt_q + 13'h0001;
      if (por_cnt_q == POR_DLY[12:0]) por_done_q <= 1'b1;       // RQ9
    end
  end

  // ======================================================
  // blank vector monitor lock, cleared only by power-on
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      blank_lock_q <= 1'b0;
    end else if (monitor_mode_i && monitor_blank_i && !irq_tst) begin
      blank_lock_q <= 1'b1;                                     // RQ14
    end
  end

  // ======================================================
  // reset output and pin drive
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_cnt_q    <= 6'h00;
      rst_pin_oe_o <= 1'b0;
      sys_reset_o  <= 1'b0;
    end else if (pin_cnt_q != 6'h00) begin
      pin_cnt_q <= pin_cnt_q - 6'h01;
      if (pin_cnt_q == 6'h01) begin
        rst_pin_oe_o <= 1'b0;
        sys_reset_o  <= 1'b0;
      end
    end else if ((ovf && !wd_off) || illop) begin               // RQ3 RQ20
      pin_cnt_q    <= PIN_LOW;                                  // RQ5
      rst_pin_oe_o <= 1'b1;
      sys_reset_o  <= 1'b1;
    end
  end
  assign rst_pin_o = 1'b0;
  assign irq_o     = 1'b0; // RQ13

  // ======================================================
  // options and reset cause registers
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      options_o     <= `OPT_RESET_VAL;                          // RQ2
      reset_cause_o <= 8'h00;
    end else begin
      if (opt_wr_i) options_o <= wdata_i;
      if (ovf && !wd_off && pin_cnt_q == 6'h00) begin
        reset_cause_o <= 8'h00;
        reset_cause_o[`CAUSE_WDOG_BIT] <= 1'b1;                 // RQ5
      end else if (illop && pin_cnt_q == 6'h00) begin
        reset_cause_o <= 8'h00;
        reset_cause_o[`CAUSE_ILLOP_BIT] <= 1'b1;                // RQ17
      end
    end
  end

  // ======================================================
  // read data and stop acknowledge
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o      <= 8'h00;
      stop_enter_o <= 1'b0;
    end else begin
      rdata_o      <= svc_rd ? vec_lo(1'b0) : 8'h00;            // RQ8
      stop_enter_o <= stop_go;
    end
  end
endmodule // runaway_code_watchdog
`default_nettype wire

// file: wdog_checker_assertions.sv
// concurrent checks on the runaway code watchdog ports
`timescale 1ns/100ps
`default_nettype none
`include "wdog_regs.vh"
module wdog_checker (
  input wire logic        mclk_i,         // clock
  input wire logic        resetn_i,       // reset, active low
  input wire logic [15:0] addr_i,         // cpu address
  input wire logic        rd_i,           // read strobe
  input wire logic        stop_exec_i,    // stop instruction
  input wire logic        monitor_mode_i, // monitor mode
  input wire logic        break_i,        // break state
  input wire logic        rst_pin_tst_i,  // test voltage on reset pin
  input wire logic        irq_pin_tst_i,  // test voltage on irq pin
  input wire logic [7:0]  rdata_o,        // read data
  input wire logic [7:0]  options_o,      // options contents
  input wire logic [7:0]  reset_cause_o,  // cause contents
  input wire logic        rst_pin_oe_o,   // reset pin drive
  input wire logic        rst_pin_o,      // reset pin level
  input wire logic        sys_reset_o,    // system reset
  input wire logic        stop_enter_o,   // stop accepted
  input wire logic        irq_o           // interrupt request
);
  logic [7:0] hi_cnt_q; // cycles the reset output has been high
  // ======================================================
  // pulse length counter
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) hi_cnt_q <= 8'h00;
    else hi_cnt_q <= sys_reset_o ? hi_cnt_q + 8'h01 : 8'h00;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // ======================================================
  // assertions
  irq_idle_a: assert property (irq_o == 1'b0) else $error("irq raised");
  pin_drive_a: assert property (rst_pin_oe_o == sys_reset_o && rst_pin_o == 1'b0)
    else $error("reset pin not driven low with reset");
  pulse_len_a: assert property ($fell(sys_reset_o) |-> hi_cnt_q == 8'h20)
    else $error("reset pulse length wrong");
  cause_set_a: assert property ($rose(sys_reset_o) |->
    reset_cause_o[`CAUSE_WDOG_BIT] || reset_cause_o[`CAUSE_ILLOP_BIT]) else $error("no cause");
  disabled_quiet_a: assert property ($rose(sys_reset_o) && !reset_cause_o[`CAUSE_ILLOP_BIT]
    |-> !$past(options_o[`OPT_DISABLE_BIT])) else $error("reset while disabled");
  monitor_quiet_a: assert property ($rose(sys_reset_o) && !reset_cause_o[`CAUSE_ILLOP_BIT]
    |-> !$past((monitor_mode_i && (irq_pin_tst_i || rst_pin_tst_i)) || (break_i && rst_pin_tst_i), 3))
    else $error("reset in monitor or break");
  read_vector_a: assert property (rd_i && addr_i == `WDOG_SERVICE_ADDR
    |=> rdata_o == `RESET_VECTOR_LO) else $error("service read wrong");
  stop_refused_a: assert property (stop_exec_i && !options_o[`OPT_STOP_EN_BIT]
    |-> ##[1:3] reset_cause_o[`CAUSE_ILLOP_BIT]) else $error("stop not refused");
  stop_taken_a: assert property (stop_exec_i && options_o[`OPT_STOP_EN_BIT]
    |-> ##[1:3] stop_enter_o) else $error("stop not taken");
  timeout_c: cover property ($rose(sys_reset_o));
  stop_c: cover property (stop_enter_o);
  read_c: cover property (rd_i && addr_i == `WDOG_SERVICE_ADDR);
endmodule // wdog_checker
bind runaway_code_watchdog wdog_checker u_chk (.mclk_i(mclk_i), .resetn_i(resetn_i),
  .addr_i(addr_i), .rd_i(rd_i), .stop_exec_i(stop_exec_i), .monitor_mode_i(monitor_mode_i),
  .break_i(break_i), .rst_pin_tst_i(rst_pin_tst_i), .irq_pin_tst_i(irq_pin_tst_i),
  .rdata_o(rdata_o), .options_o(options_o), .reset_cause_o(reset_cause_o),
  .rst_pin_oe_o(rst_pin_oe_o), .rst_pin_o(rst_pin_o), .sys_reset_o(sys_reset_o),
  .stop_enter_o(stop_enter_o), .irq_o(irq_o));
`default_nettype wire

// file: wdog_cpu_model.sv
// cpu bus model issuing watchdog service and options cycles
`timescale 1ns/100ps
`default_nettype none
module wdog_cpu_model (
  input  wire logic        mclk_i,   // clock
  output logic      [15:0] addr_o,   // address
  output logic      [7:0]  wdata_o,  // write data
  output logic             wr_o,     // write strobe
  output logic             rd_o,     // read strobe
  output logic             opt_wr_o, // options write strobe
  input  wire logic [7:0]  rdata_i   // read data
);
  initial begin
    {addr_o, wdata_o, wr_o, rd_o, opt_wr_o} = 27'h0000000;
  end
  // one-cycle access, lines scrambled once released
  task automatic cycle(input logic [15:0] a, input logic [7:0] d, input logic [2:0] s);
    @(posedge mclk_i);
    #1;
    {addr_o, wdata_o, wr_o, rd_o, opt_wr_o} = {a, d, s};
    @(posedge mclk_i);
    #1;
    {addr_o, wdata_o, wr_o, rd_o, opt_wr_o} = {~a, ~d, 3'h0};
  endtask
  task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
    cycle(a, d, 3'h4);
  endtask
  task automatic opt_write(input logic [7:0] d);
    cycle(16'h0000, d, 3'h1);
  endtask
  task automatic bus_read(input logic [15:0] a, output logic [7:0] d);
    cycle(a, 8'h00, 3'h2);
    d = rdata_i;
  endtask
endmodule // wdog_cpu_model
`default_nettype wire

// file: tb_runaway_code_watchdog.sv
// self-checking bench for the runaway code watchdog
`timescale 1ns/100ps
`default_nettype none
`include "wdog_regs.vh"
module tb_runaway_code_watchdog;
  logic        mclk_i = 0, resetn_i = 0, wait_i = 0, mon_i = 0, brk_i = 0;
  logic        rtst_i = 0, itst_i = 0, stop_i = 0, vfetch_i = 0, ireset_i = 0, blank_i = 0;
  wire  [15:0] addr;
  wire  [7:0]  wdata, rdata, opts, cause;
  wire         wr, rd, opt_wr, pin_oe, pin, sys_rst, stop_ok, irq;
  int          fail_count = 0, compares = 0;
  initial forever #2 mclk_i = ~mclk_i;
  wdog_cpu_model cpu (.mclk_i(mclk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
    .opt_wr_o(opt_wr), .rdata_i(rdata));
  runaway_code_watchdog #(.POR_DLY(16)) dut (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .vector_fetch_i(vfetch_i),
    .opt_wr_i(opt_wr), .stop_exec_i(stop_i), .wait_mode_i(wait_i), .monitor_mode_i(mon_i),
    .monitor_blank_i(blank_i), .break_i(brk_i), .rst_pin_tst_i(rtst_i), .irq_pin_tst_i(itst_i),
    .int_reset_i(ireset_i), .rdata_o(rdata), .options_o(opts), .reset_cause_o(cause),
    .rst_pin_oe_o(pin_oe), .rst_pin_o(pin), .sys_reset_o(sys_rst), .stop_enter_o(stop_ok),
    .irq_o(irq));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // cycles until the system reset shows, bounded
  task automatic wait_sys(input int lim, output int n);
    n = 0;
    while (sys_rst !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
  endtask
  task automatic reset_dut;
    resetn_i = 0;
    tick(2);
    resetn_i = 1;
    // let the power-on prescaler clear pass before timing anything
    tick(20);
    cpu.bus_write(`WDOG_SERVICE_ADDR, 8'h5A);
  endtask
  task automatic t_reset_read;
    logic [7:0] d;
    reset_dut();
    check("options after reset", opts, `OPT_RESET_VAL);
    cpu.bus_read(`WDOG_SERVICE_ADDR, d);
    check("service read", d, `RESET_VECTOR_LO);
    $display("test reset_read done");
  endtask
  task automatic t_timeout;
    int n;
    cpu.opt_write(8'h01);
    wait_i = 1;
    cpu.bus_write(`WDOG_SERVICE_ADDR, 8'hC3);
    wait_sys(9000, n);
    if (n == 9000) fail_count++;
    check("timeout window", 8'(n >= 8170 && n <= 8200), 8'h01);
    check("cause flag", 8'(cause[`CAUSE_WDOG_BIT]), 8'h01);
    check("irq", 8'(irq), 8'h00);
    wait_sys(0, n);
    while (sys_rst === 1'b1 && n < 100) begin
      check("pin drive", 8'(pin_oe), 8'h01);
      check("pin level", 8'(pin), 8'h00);
      tick(1);
      n++;
    end
    check("pulse length", 8'(n), 8'h20);
    wait_i = 0;
    $display("test timeout done");
  endtask
  // disable bit, monitor and break each keep the reset away
  task automatic t_quiet;
    int n;
    for (int k = 0; k < 4; k++) begin
      reset_dut();
      cpu.opt_write(k == 0 ? 8'h03 : 8'h01);
      {mon_i, itst_i, brk_i, rtst_i} = (k == 1) ? 4'hC : (k == 2) ? 4'h3 : 4'h0;
      // blank vector entry without irq test voltage, then leave monitor mode
      {mon_i, blank_i} = {mon_i || k == 3, k == 3};
      cpu.bus_write(`WDOG_SERVICE_ADDR, 8'h00);
      if (k == 3) {mon_i, blank_i} = 2'h0;
      wait_sys(9000, n);
      check("no reset", 8'(n == 9000), 8'h01);
      {mon_i, itst_i, brk_i, rtst_i} = 4'h0;
    end
    $display("test quiet done");
  endtask
  task automatic t_stop;
    int n;
    for (int k = 0; k < 2; k++) begin
      reset_dut();
      cpu.opt_write(k == 0 ? 8'h01 : 8'h05);
      stop_i = 1;
      tick(1);
      check("stop accepted", 8'(stop_ok), 8'(k == 1));
      stop_i = 0;
      tick(3);
      check("illegal stop cause", 8'(cause[`CAUSE_ILLOP_BIT]), 8'(k == 0));
      if (k == 1) wait_sys(9000, n);
      if (k == 1) check("frozen in stop", 8'(n == 9000), 8'h01);
    end
    $display("test stop done");
  endtask
  // vector fetch clears the prescaler only, internal reset clears both
  task automatic t_clears;
    int n;
    for (int k = 0; k < 2; k++) begin
      reset_dut();
      cpu.opt_write(8'h01);
      cpu.bus_write(`WDOG_SERVICE_ADDR, 8'h00);
      tick(4000);
      {vfetch_i, ireset_i} = (k == 0) ? 2'h2 : 2'h1;
      tick(1);
      {vfetch_i, ireset_i} = 2'h0;
      wait_sys(9000, n);
      // 31 ticks of 128 kept by a fetch, 33 more to go, plus the output flop
      if (k == 0) check("fetch clear", 8'(n == 4225), 8'h01);
      // a full 2^13 period after an internal reset, plus the output flop
      if (k == 1) check("internal reset clear", 8'(n == 8193), 8'h01);
    end
    $display("test clears done");
  endtask
  initial begin
    t_reset_read();
    t_timeout();
    t_quiet();
    t_stop();
    t_clears();
    print_verdict();
  end
endmodule // tb_runaway_code_watchdog
`default_nettype wire
